// ---- xie_xor_exec.sv ----
// Four-phase decode and execute of the two exclusive-OR instructions
//
// Contract
// RL1 - Literal XOR into working register, zero only
// RL2 - File XOR with addressed register, zero only
// RL3 - Destination clear: result to working register
// RL4 - Destination set: result back to file
// RL5 - One word, one cycle, four ordered phases
// RL6 - File XOR opcode top bits 000110
`timescale 1ns/100ps
module xie_xor_exec
  import xie_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                instr_valid,
  input  wire logic [INSTR_W-1:0]  instr,
  input  wire logic [DATA_W-1:0]   file_rd_data,
  output xie_phase_t               phase,
  output logic                     file_rd_en,
  output logic [ADDR_W-1:0]        file_addr,
  output logic                     file_wr_en,
  output logic [DATA_W-1:0]        file_wr_data,
  output logic [DATA_W-1:0]        w_reg,
  output logic                     zero_flag,
  output logic                     done,
  output logic                     unknown_op
);

  // Decoded instruction state
  xie_op_t            op;            // Operation latched at end of Q1
  logic               dest;          // Destination select
  logic [DATA_W-1:0]  operand;       // Second operand, literal or file data
  logic [DATA_W-1:0]  result;        // Result held from Q3 into Q4
  logic               result_zero;   // Zero of held result

  // Next values
  xie_phase_t         next_phase;
  xie_op_t            next_op;
  logic               next_dest;
  logic [DATA_W-1:0]  next_operand;
  logic [DATA_W-1:0]  next_result;
  logic               next_result_zero;
  logic               next_file_rd_en;
  logic [ADDR_W-1:0]  next_file_addr;
  logic               next_file_wr_en;
  logic [DATA_W-1:0]  next_file_wr_data;
  logic [DATA_W-1:0]  next_w_reg;
  logic               next_zero_flag;
  logic               next_done;
  logic               next_unknown_op;

  // Decode helpers, pure views of the incoming word
  logic [5:0]         opc;
  logic               is_lit;
  logic               is_file;

  // XOR unit connection
  xie_alu_if alu_bus ();

  xie_xor_alu u_alu (
    .alu (alu_bus.alu)
  );

  // Working register is always operand A; B is the latched operand
  assign alu_bus.opnd_a = w_reg;
  assign alu_bus.opnd_b = operand;

  // Opcode field split
  assign opc     = instr[OPC_HI:OPC_LO];
  // RL1 literal opcode match
  assign is_lit  = (opc == OPC_XOR_LIT);
  // RL6 file opcode match
  assign is_file = (opc == OPC_XOR_FILE);

  // Next-state logic for the whole sequencer
  always_comb begin
    next_phase        = phase;
    next_op           = op;
    next_dest         = dest;
    next_operand      = operand;
    next_result       = result;
    next_result_zero  = result_zero;
    next_file_rd_en   = 1'b0;
    next_file_addr    = file_addr;
    next_file_wr_en   = 1'b0;
    next_file_wr_data = file_wr_data;
    next_w_reg        = w_reg;
    next_zero_flag    = zero_flag;
    next_done         = 1'b0;
    next_unknown_op   = unknown_op;
    case (phase)
      // RL5 decode in first phase
      XIE_Q1: begin
        next_phase = XIE_Q2;
        next_op    = XIE_OP_NONE;
        next_dest  = DEST_W;
        if (instr_valid) begin
          next_unknown_op = !(is_lit || is_file);
          if (is_lit) begin
            // RL1 literal is the operand
            next_op      = XIE_OP_LIT;
            next_operand = instr[LIT_HI:0];
          end else if (is_file) begin
            // RL2 request file read in Q2
            next_op         = XIE_OP_FILE;
            next_dest       = instr[DEST_BIT];
            next_file_addr  = instr[ADDR_HI:0];
            next_file_rd_en = 1'b1;
          end
        end
      end
      // RL5 operand read in second phase
      XIE_Q2: begin
        next_phase = XIE_Q3;
        if (op == XIE_OP_FILE) begin
          next_operand = file_rd_data;
        end
      end
      // RL5 process data in third phase
      XIE_Q3: begin
        next_phase       = XIE_Q4;
        next_result      = alu_bus.result;
        next_result_zero = alu_bus.zero;
        // RL4 file write staged for Q4
        if (op == XIE_OP_FILE && dest == DEST_FILE) begin
          next_file_wr_en   = 1'b1;
          next_file_wr_data = alu_bus.result;
        end
      end
      // RL5 destination write in fourth phase
      XIE_Q4: begin
        next_phase = XIE_Q1;
        if (op != XIE_OP_NONE) begin
          // RL1 zero is the only status touched
          next_zero_flag = result_zero;
          next_done      = 1'b1;
        end
        // RL3 working register written when dest clear
        if (op == XIE_OP_LIT || (op == XIE_OP_FILE && dest == DEST_W)) begin
          next_w_reg = result;
        end
      end
      default: begin
        // Unreachable with two-bit phase; recover to decode
        next_phase = XIE_Q1;
      end
    endcase
  end

  // State registers only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase        <= XIE_Q1;
      op           <= XIE_OP_NONE;
      dest         <= DEST_W;
      operand      <= ZERO_BYTE;
      result       <= ZERO_BYTE;
      result_zero  <= 1'b0;
      file_rd_en   <= 1'b0;
      file_addr    <= ADDR_RESET;
      file_wr_en   <= 1'b0;
      file_wr_data <= ZERO_BYTE;
      w_reg        <= W_RESET;
      zero_flag    <= 1'b0;
      done         <= 1'b0;
      unknown_op   <= 1'b0;
    end else begin
      phase        <= next_phase;
      op           <= next_op;
      dest         <= next_dest;
      operand      <= next_operand;
      result       <= next_result;
      result_zero  <= next_result_zero;
      file_rd_en   <= next_file_rd_en;
      file_addr    <= next_file_addr;
      file_wr_en   <= next_file_wr_en;
      file_wr_data <= next_file_wr_data;
      w_reg        <= next_w_reg;
      zero_flag    <= next_zero_flag;
      done         <= next_done;
      unknown_op   <= next_unknown_op;
    end
  end

  // Checks beside the logic
  // RL5 phases advance in fixed order
  AST_PHASE_ORDER: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
    (phase == XIE_Q1) |=> (phase == XIE_Q2) ##1 (phase == XIE_Q3) ##1 (phase == XIE_Q4))
    else $error("phase order broken");

  // RL1 literal result reaches working register four edges later
  AST_LIT_RESULT: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
    (phase == XIE_Q1 && instr_valid && is_lit)
    |-> ##4 (w_reg == ($past(w_reg, 4) ^ $past(instr[LIT_HI:0], 4))
             && zero_flag == (w_reg == ZERO_BYTE) && !file_wr_en))
    else $error("literal xor result wrong");

  // RL2 file read issued with the decoded address
  AST_FILE_READ: assert property (@(posedge core_clk) disable iff (!rstn) // RL2
    (phase == XIE_Q1 && instr_valid && is_file)
    |=> file_rd_en && file_addr == $past(instr[ADDR_HI:0]) && phase == XIE_Q2)
    else $error("file read not issued");

  // RL3 working register destination leaves the file alone
  AST_DEST_W: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
    (phase == XIE_Q1 && instr_valid && is_file && !instr[DEST_BIT])
    |-> ##2 (!file_wr_en [*3]) ##0 (w_reg == ($past(w_reg, 4) ^ $past(file_rd_data, 3))))
    else $error("w destination wrong");

  // RL4 file destination writes file in Q4, keeps working register
  AST_DEST_F: assert property (@(posedge core_clk) disable iff (!rstn) // RL4
    (phase == XIE_Q1 && instr_valid && is_file && instr[DEST_BIT])
    |-> ##3 (file_wr_en && phase == XIE_Q4
             && file_wr_data == (w_reg ^ $past(file_rd_data, 2)))
        ##1 $stable(w_reg))
    else $error("file destination wrong");

  // RL6 file write only ever follows a file opcode
  AST_WR_CAUSE: assert property (@(posedge core_clk) disable iff (!rstn) // RL6
    $rose(file_wr_en) |-> $past(op == XIE_OP_FILE && dest == DEST_FILE))
    else $error("spurious file write");

  // RL5 completion only after fourth phase
  AST_DONE_SLOT: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
    done |-> phase == XIE_Q1 && $past(phase == XIE_Q4 && op != XIE_OP_NONE))
    else $error("done out of slot");

  // RL1 zero flag never moves outside the write phase
  AST_ZERO_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
    (phase != XIE_Q1) |-> $stable(zero_flag))
    else $error("zero flag changed early");

endmodule

// ---- xie_pkg.sv ----
// Constants and types for the exclusive-OR execute block
package xie_pkg;
  // Instruction word layout
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int OPC_HI      = 13;
  localparam int OPC_LO      = 8;
  localparam int DEST_BIT    = 7;
  localparam int ADDR_HI     = 6;
  localparam int LIT_HI      = 7;
  // Opcode prefixes in bits 13..8
  localparam logic [5:0] OPC_XOR_LIT  = 6'h3A;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  // Destination select values
  localparam logic DEST_W    = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // Reset values
  localparam logic [DATA_W-1:0] W_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

  // Instruction cycle phases
  typedef enum logic [1:0] {
    XIE_Q1 = 2'b00,
    XIE_Q2 = 2'b01,
    XIE_Q3 = 2'b10,
    XIE_Q4 = 2'b11
  } xie_phase_t;

  // Decoded operation
  typedef enum logic [1:0] {
    XIE_OP_NONE = 2'b00,
    XIE_OP_LIT  = 2'b01,
    XIE_OP_FILE = 2'b10
  } xie_op_t;
endpackage

// ---- xie_alu_if.sv ----
// Carrier between the execute sequencer and its XOR unit
`timescale 1ns/100ps
interface xie_alu_if;
  logic [7:0] opnd_a;   // Working register side
  logic [7:0] opnd_b;   // Literal or file operand
  logic [7:0] result;   // XOR result
  logic       zero;     // Result is all zero
  modport core (output opnd_a, output opnd_b, input result, input zero);
  modport alu  (input opnd_a, input opnd_b, output result, output zero);
endinterface

// ---- xie_xor_alu.sv ----
// Combinational XOR unit with zero detect
`timescale 1ns/100ps
module xie_xor_alu
  import xie_pkg::*;
(
  xie_alu_if.alu alu
);
  // Plain XOR; zero flag is the only status this unit makes
  always_comb begin
    alu.result = alu.opnd_a ^ alu.opnd_b;
    alu.zero   = ((alu.opnd_a ^ alu.opnd_b) == ZERO_BYTE);
  end
endmodule

// ---- xie_xor_exec_tb.sv ----
// Self-checking bench for the exclusive-OR execute block
`timescale 1ns/100ps
module xie_xor_exec_tb;
  import xie_pkg::*;
  logic               core_clk;      // Core clock, 100 MHz
  logic               rstn;          // Async reset, active low
  logic               instr_valid;   // Word present
  logic [INSTR_W-1:0] instr;         // Instruction word
  logic [DATA_W-1:0]  file_rd_data;  // File register read data
  xie_phase_t         phase;         // Current phase
  logic               file_rd_en;    // File read strobe
  logic [ADDR_W-1:0]  file_addr;     // File address
  logic               file_wr_en;    // File write strobe
  logic [DATA_W-1:0]  file_wr_data;  // File write data
  logic [DATA_W-1:0]  w_reg;         // Working register
  logic               zero_flag;     // Zero status
  logic               done;          // Completion pulse
  logic               unknown_op;    // Not an XOR word
  int                 num_errors;    // Mismatches
  int                 checks_done;   // Comparisons made
  int                 cycles;        // Hang guard

  xie_xor_exec u_dut (
    .core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .file_rd_data(file_rd_data), .phase(phase), .file_rd_en(file_rd_en),
    .file_addr(file_addr), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .w_reg(w_reg), .zero_flag(zero_flag), .done(done), .unknown_op(unknown_op)
  );

  // Clock, 10 ns period
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard: the whole run needs well under 200 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 500) begin
      num_errors++;
      $display("ERROR at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  // Count and report one comparison
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  // Land just after the next rising edge
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // One word through all four phases, judged phase by phase
  task automatic run_op(input logic [13:0] word, input logic [7:0] rd_val,
      input logic rd, input logic wr, input logic [7:0] wd,
      input logic [7:0] exp_w, input logic exp_z, input logic dn, input logic unk);
    chk(phase === XIE_Q1, "word not offered in first phase");
    instr_valid = 1'h1;
    instr = word;
    step();
    // Valid stays up with another XOR: must be ignored outside the first phase
    instr = 14'h3AFF;
    chk(phase === XIE_Q2 && file_rd_en === rd, "operand read phase wrong");
    if (rd) begin
      chk(file_addr === word[6:0], "file address wrong");
      file_rd_data = rd_val;
    end
    step();
    // Read released: show the inverse so stale data cannot pass
    file_rd_data = ~rd_val;
    chk(phase === XIE_Q3 && file_rd_en === 1'h0, "process phase wrong");
    step();
    chk(phase === XIE_Q4 && file_wr_en === wr, "write phase strobe wrong");
    if (wr) chk(file_wr_data === wd, "file write data wrong");
    step();
    // Valid left up: the next word follows back to back; the next run_op assigns it high again
    chk(phase === XIE_Q1 && done === dn && unknown_op === unk, "completion wrong");
    chk(w_reg === exp_w && zero_flag === exp_z, "working register or zero wrong");
  endtask

  // Closing report, the single exit of the run
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Literal chain from reset value, ending in a zero result and a reload
  task automatic scen_literal();
    run_op(14'h3AB5, 8'h00, 1'h0, 1'h0, 8'h00, 8'hB5, 1'h0, 1'h1, 1'h0);
    run_op(14'h3AAF, 8'h00, 1'h0, 1'h0, 8'h00, 8'h1A, 1'h0, 1'h1, 1'h0);
    run_op(14'h3A1A, 8'h00, 1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0);
    run_op(14'h3AB5, 8'h00, 1'h0, 1'h0, 8'h00, 8'hB5, 1'h0, 1'h1, 1'h0);
  endtask

  // File forms: write back, a foreign word, then working register destination
  task automatic scen_file_mix();
    run_op(14'h06FF, 8'hAF, 1'h1, 1'h1, 8'h1A, 8'hB5, 1'h0, 1'h1, 1'h0);
    run_op(14'h0EFF, 8'h00, 1'h0, 1'h0, 8'h00, 8'hB5, 1'h0, 1'h0, 1'h1);
    run_op(14'h0600, 8'hB5, 1'h1, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0);
  endtask

  // Literal then file write back, with a zero result on the file side
  task automatic scen_back_to_back();
    run_op(14'h3AFF, 8'h00, 1'h0, 1'h0, 8'h00, 8'hFF, 1'h0, 1'h1, 1'h0);
    run_op(14'h0685, 8'hFF, 1'h1, 1'h1, 8'h00, 8'hFF, 1'h1, 1'h1, 1'h0);
  endtask

  // Valid low while an XOR word sits on the bus: nothing may happen
  task automatic scen_idle();
    instr_valid = 1'h0;
    repeat (4) begin
      step();
      chk(done === 1'h0 && file_wr_en === 1'h0, "activity while idle");
      chk(w_reg === 8'hFF && zero_flag === 1'h1, "state moved while idle");
    end
  endtask

  // Main sequence, back to back on every first phase
  initial begin
    rstn = 1'h0;
    instr_valid = 1'h0;
    instr = 14'h0000;
    file_rd_data = 8'h00;
    repeat (20) @(posedge core_clk);
    #1;
    rstn = 1'h1;
    chk(phase === XIE_Q1 && w_reg === 8'h00 && zero_flag === 1'h0 && done === 1'h0,
        "reset values");
    scen_literal();
    scen_file_mix();
    scen_back_to_back();
    scen_idle();
    print_verdict();
  end
endmodule
